// *** logic/ccs_sequencer.sv ***
// calibration command sequencer with ahb-lite register slave
`timescale 1ns/1ps
// Operation
// - date year 1998-2097, month 1-12, day 1-31
// - date kept nonvolatile, query returns three fields
// - begin required before step, save, date
// - constants reach nonvolatile store only on save
// - save skipped if locked, invalid, incomplete, disordered
// - step number must equal expected index
// - step performs its point action with argument
// - step failure queues numbered error entry
// - error-available bit 2 set while queue nonempty
// - reading error entry removes it
// - mask value 4 raises service request
// - channel 1 codes 404-416
// - channel 2 codes offset by twenty
// - steps 0-8 channel 1, 9-17 channel 2
// - begin, step, save, date refused while locked
module ccs_sequencer
  import ccs_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // analog step engine
  output logic step_go,
  output logic [4:0] step_num,
  output logic [31:0] step_arg,
  input wire logic step_done,
  input wire logic step_fail,
  input wire logic [1:0] step_fault,
  input wire logic [31:0] step_value,
  // nonvolatile constant store
  output logic nv_we,
  output logic [4:0] nv_addr,
  output logic [31:0] nv_wdata,
  // service request and interrupt
  output logic srq,
  output logic irq
);
  typedef enum logic [1:0] {CCS_IDLE, CCS_STEP, CCS_SAVE} ccs_state_t;

  // ==========================================
  // bus slave
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic ap, rd_ap, errq_pop;
  logic [31:0] arg_q, arg_d, date_w_q, date_w_d;
  logic [7:0] sre_q, sre_d;
  logic [CCS_IRQ_W-1:0] ist_q, ist_d, ien_q, ien_d, iset;
  ccs_cal_t cal_q, cal_d;
  ccs_date_t date_q, date_d, date_in;
  ccs_state_t st_q, st_d;
  logic [31:0] const_q [CCS_STEP_COUNT];
  logic go_q, go_d, nv_we_q, nv_we_d, srq_q, irq_q;
  logic [4:0] num_q, num_d, nv_addr_q, nv_addr_d;
  logic [31:0] nv_wdata_q, nv_wdata_d;
  logic push;
  logic [15:0] push_code, eq_head;
  logic eq_empty;
  logic [3:0] eq_count;
  logic [7:0] sb;
  logic cmd_wr, save_ok, const_we;
  logic [2:0] op;
  logic [4:0] cmd_step;

  assign ap = hsel && htrans[1] && hready;
  assign rd_ap = ap && !hwrite;
  assign errq_pop = rd_ap && haddr[7:0] == CCS_A_ERRQ;
  assign sb = {5'h0, !eq_empty, 2'h0};

  always_comb begin
    wr_pend_d = ap && hwrite;
    wr_addr_d = haddr[7:0];
    rdata_d = 32'h0;
    if (rd_ap) begin
      unique case (haddr[7:0])
        CCS_A_ARG: rdata_d = arg_q;
        CCS_A_DATE: rdata_d = date_w_q;
        CCS_A_DATE_Q: rdata_d = {4'h0, date_q.year, 4'h0, date_q.month, 3'h0, date_q.day};
        CCS_A_STAT: rdata_d = {4'h0, eq_count, sb, 4'h0, st_q != CCS_IDLE, 2'h0, cal_q};
        CCS_A_ERRQ: rdata_d = {16'h0, eq_head};
        CCS_A_SRE: rdata_d = {24'h0, sre_q};
        CCS_A_IRQ_ST: rdata_d = {29'h0, ist_q};
        CCS_A_IRQ_EN: rdata_d = {29'h0, ien_q};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h0;
      rdata_q <= 32'h0;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q <= rdata_d;
    end
  end

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // ==========================================
  // software registers and interrupt
  assign cmd_wr = wr_pend_q && wr_addr_q == CCS_A_CMD;
  assign op = hwdata[2:0];
  assign cmd_step = hwdata[CCS_CMD_STEP_LSB +: 5];

  always_comb begin
    arg_d = (wr_pend_q && wr_addr_q == CCS_A_ARG) ? hwdata : arg_q;
    date_w_d = (wr_pend_q && wr_addr_q == CCS_A_DATE) ? hwdata : date_w_q;
    sre_d = (wr_pend_q && wr_addr_q == CCS_A_SRE) ? hwdata[7:0] : sre_q;
    ien_d = (wr_pend_q && wr_addr_q == CCS_A_IRQ_EN) ? hwdata[CCS_IRQ_W-1:0] : ien_q;
    ist_d = ist_q;
    if (wr_pend_q && wr_addr_q == CCS_A_IRQ_CLR) begin
      ist_d = ist_q & ~hwdata[CCS_IRQ_W-1:0];
    end
    // a new event beats a clear in the same cycle
    ist_d = ist_d | iset;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arg_q <= 32'h0;
      date_w_q <= 32'h0;
      sre_q <= CCS_SRE_RESET;
      ien_q <= '0;
      ist_q <= '0;
      srq_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      arg_q <= arg_d;
      date_w_q <= date_w_d;
      sre_q <= sre_d;
      ien_q <= ien_d;
      ist_q <= ist_d;
      srq_q <= |(sb & sre_q);
      irq_q <= |(ist_d & ien_d);
    end
  end

  // ==========================================
  // sequencer
  // fields split at their own positions, as the controller delimits them
  assign date_in = '{year: date_w_q[CCS_YEAR_LSB +: 12], month: date_w_q[CCS_MONTH_LSB +: 4],
    day: date_w_q[CCS_DAY_LSB +: 5]};
  assign save_ok = cal_q.unlocked && !cal_q.invalid && !cal_q.seq_bad
    && cal_q.idx == CCS_STEP_COUNT;

  always_comb begin
    cal_d = cal_q;
    date_d = date_q;
    st_d = st_q;
    go_d = 1'b0;
    num_d = num_q;
    nv_we_d = 1'b0;
    nv_addr_d = nv_addr_q;
    nv_wdata_d = nv_wdata_q;
    push = 1'b0;
    push_code = 16'h0;
    iset = '0;
    const_we = 1'b0;
    unique case (st_q)
      CCS_IDLE: begin
        if (cmd_wr) begin
          if (op == CCS_OP_UNLOCK) begin
            cal_d.unlocked = arg_q == CCS_PASSCODE;
          end else if (op == CCS_OP_LOCK) begin
            cal_d = '0;
          end else if (op >= CCS_OP_INIT && op <= CCS_OP_DATE && !cal_q.unlocked) begin
            push = 1'b1;
            push_code = CCS_ERR_LOCKED;
          end else if (op == CCS_OP_INIT) begin
            cal_d = '{unlocked: 1'b1, begun: 1'b1, invalid: 1'b0, seq_bad: 1'b0, idx: 5'h0};
          end else if (op >= CCS_OP_STEP && op <= CCS_OP_DATE && !cal_q.begun) begin
            push = 1'b1;
            push_code = CCS_ERR_SEQ;
          end else if (op == CCS_OP_STEP) begin
            if (cmd_step != cal_q.idx) begin
              push = 1'b1;
              push_code = CCS_ERR_SEQ;
              cal_d.seq_bad = 1'b1;
            end else begin
              go_d = 1'b1;
              num_d = cmd_step;
              st_d = CCS_STEP;
            end
          end else if (op == CCS_OP_SAVE) begin
            if (save_ok) begin
              st_d = CCS_SAVE;
              nv_addr_d = 5'h0;
            end else begin
              iset[CCS_IRQ_SAVE_REF] = 1'b1;
            end
          end else if (op == CCS_OP_DATE) begin
            if (ccs_date_ok(date_in)) begin
              date_d = date_in;
              nv_we_d = 1'b1;
              nv_addr_d = CCS_NV_DATE_ADDR;
              nv_wdata_d = {4'h0, date_in.year, 4'h0, date_in.month, 3'h0, date_in.day};
            end else begin
              push = 1'b1;
              push_code = CCS_ERR_DATE;
            end
          end
        end
      end
      CCS_STEP: begin
        // other commands are dropped while the analog step runs
        if (step_done) begin
          st_d = CCS_IDLE;
          if (step_fail) begin
            push = 1'b1;
            push_code = ccs_err_code(num_q, step_fault);
            cal_d.invalid = 1'b1;
            iset[CCS_IRQ_STEP_ERR] = 1'b1;
          end else begin
            const_we = 1'b1;
            cal_d.idx = cal_q.idx + 5'h1;
          end
        end
      end
      CCS_SAVE: begin
        nv_we_d = 1'b1;
        nv_addr_d = nv_we_q ? nv_addr_q + 5'h1 : 5'h0;
        if (nv_we_q && nv_addr_q == CCS_STEP_COUNT - 5'h1) begin
          nv_we_d = 1'b0;
          nv_addr_d = nv_addr_q;
          st_d = CCS_IDLE;
          iset[CCS_IRQ_SAVE_OK] = 1'b1;
        end
        // read after the end test so the index never runs past the last constant
        nv_wdata_d = const_q[nv_addr_d];
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cal_q <= '0;
      date_q <= '0;
      st_q <= CCS_IDLE;
      go_q <= 1'b0;
      num_q <= 5'h0;
      nv_we_q <= 1'b0;
      nv_addr_q <= 5'h0;
      nv_wdata_q <= 32'h0;
    end else begin
      cal_q <= cal_d;
      date_q <= date_d;
      st_q <= st_d;
      go_q <= go_d;
      num_q <= num_d;
      nv_we_q <= nv_we_d;
      nv_addr_q <= nv_addr_d;
      nv_wdata_q <= nv_wdata_d;
    end
  end

  // volatile working constants, one per step
  always_ff @(posedge hclk) begin
    if (const_we) begin
      const_q[num_q] <= step_value;
    end
  end

  assign step_go = go_q;
  assign step_num = num_q;
  assign step_arg = arg_q;
  assign nv_we = nv_we_q;
  assign nv_addr = nv_addr_q;
  assign nv_wdata = nv_wdata_q;
  assign srq = srq_q;
  assign irq = irq_q;

  ccs_err_queue u_errq (
    .hclk(hclk),
    .hresetn(hresetn),
    .push(push),
    .push_code(push_code),
    .pop(errq_pop),
    .head(eq_head),
    .empty(eq_empty),
    .count(eq_count)
  );

  // ==========================================
  // checks
  date_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == CCS_IDLE && cmd_wr && op == CCS_OP_DATE && cal_q.begun && date_in.month == 4'h0
    |=> $stable(date_q) && !nv_we_q) else $error("bad date stored");
  begin_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == CCS_IDLE && cmd_wr && op == CCS_OP_STEP && !cal_q.begun |=> !step_go)
    else $error("step ran before begin");
  save_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == CCS_IDLE && cmd_wr && op == CCS_OP_SAVE && cal_q.begun && cal_q.idx != CCS_STEP_COUNT
    |=> st_q == CCS_IDLE ##1 !nv_we) else $error("incomplete save written");
  save_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == CCS_IDLE && cmd_wr && op == CCS_OP_SAVE && save_ok
    |=> ##1 nv_we && nv_addr == 5'h0) else $error("save did not start");
  seq_err_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == CCS_IDLE && cmd_wr && op == CCS_OP_STEP && cal_q.begun && cmd_step != cal_q.idx
    |=> cal_q.seq_bad && !step_go && !eq_empty) else $error("out of order step ran");
  step_adv_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == CCS_STEP && step_done && !step_fail |=> cal_q.idx == $past(cal_q.idx) + 5'h1)
    else $error("step index not advanced");
  step_err_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == CCS_STEP && step_done && step_fail |=> cal_q.invalid && !eq_empty)
    else $error("step failure not queued");
  srq_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sre_q == 8'h04 && !eq_empty && $stable(sre_q) |=> srq) else $error("no service request");
  pop_last_a: assert property (@(posedge hclk) disable iff (!hresetn)
    errq_pop && eq_count == 4'h1 && !push |=> eq_empty && !sb[CCS_SB_EAV])
    else $error("error entry not removed");
  lock_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == CCS_IDLE && cmd_wr && op == CCS_OP_LOCK |=> cal_q == '0) else $error("lock left state");
endmodule

// *** shared/ccs_pkg.sv ***
// constants, types and helpers of the calibration command sequencer
package ccs_pkg;
  // ==========================================
  // register offsets
  localparam logic [7:0] CCS_A_CMD = 8'h00;
  localparam logic [7:0] CCS_A_ARG = 8'h04;
  localparam logic [7:0] CCS_A_DATE = 8'h08;
  localparam logic [7:0] CCS_A_DATE_Q = 8'h0c;
  localparam logic [7:0] CCS_A_STAT = 8'h10;
  localparam logic [7:0] CCS_A_ERRQ = 8'h14;
  localparam logic [7:0] CCS_A_SRE = 8'h18;
  localparam logic [7:0] CCS_A_IRQ_ST = 8'h1c;
  localparam logic [7:0] CCS_A_IRQ_CLR = 8'h20;
  localparam logic [7:0] CCS_A_IRQ_EN = 8'h24;
  // ==========================================
  // command codes, cmd[2:0]; step number in cmd[12:8]
  localparam logic [2:0] CCS_OP_UNLOCK = 3'h1;
  localparam logic [2:0] CCS_OP_LOCK = 3'h2;
  localparam logic [2:0] CCS_OP_INIT = 3'h3;
  localparam logic [2:0] CCS_OP_STEP = 3'h4;
  localparam logic [2:0] CCS_OP_SAVE = 3'h5;
  localparam logic [2:0] CCS_OP_DATE = 3'h6;
  localparam int CCS_CMD_STEP_LSB = 8;
  // unlock passcode, value arbitrary
  localparam logic [31:0] CCS_PASSCODE = 32'h5a5a_0001;
  // ==========================================
  // date fields and limits
  localparam int CCS_YEAR_LSB = 16;
  localparam int CCS_MONTH_LSB = 8;
  localparam int CCS_DAY_LSB = 0;
  localparam logic [11:0] CCS_YEAR_MIN = 12'h7ce;
  localparam logic [11:0] CCS_YEAR_MAX = 12'h831;
  localparam logic [3:0] CCS_MONTH_MAX = 4'hc;
  localparam logic [4:0] CCS_DAY_MAX = 5'h1f;
  // ==========================================
  // steps, status and error codes
  localparam logic [4:0] CCS_STEP_COUNT = 5'h12;
  localparam logic [4:0] CCS_STEPS_PER_CH = 5'h09;
  localparam logic [4:0] CCS_NV_DATE_ADDR = 5'h12;
  localparam int CCS_SB_EAV = 2;
  localparam logic [7:0] CCS_SRE_RESET = 8'h00;
  localparam logic [15:0] CCS_CH2_OFS = 16'h0014;
  localparam logic [15:0] CCS_ERR_TRIG_BASE = 16'h019d;
  localparam logic [15:0] CCS_ERR_SEQ = 16'h00c8;
  localparam logic [15:0] CCS_ERR_DATE = 16'h00c9;
  localparam logic [15:0] CCS_ERR_LOCKED = 16'h00ca;
  localparam int CCS_ERR_DEPTH = 8;
  localparam int CCS_IRQ_STEP_ERR = 0;
  localparam int CCS_IRQ_SAVE_OK = 1;
  localparam int CCS_IRQ_SAVE_REF = 2;
  localparam int CCS_IRQ_W = 3;

  typedef struct packed {
    logic unlocked;
    logic begun;
    logic invalid;
    logic seq_bad;
    logic [4:0] idx;
  } ccs_cal_t;

  typedef struct packed {
    logic [11:0] year;
    logic [3:0] month;
    logic [4:0] day;
  } ccs_date_t;

  // failure code of a step; fault 1..3 are the trigger-level faults
  function automatic logic [15:0] ccs_err_code(input logic [4:0] step, input logic [1:0] fault);
    logic [4:0] pt;
    logic [15:0] base;
    pt = (step >= CCS_STEPS_PER_CH) ? step - CCS_STEPS_PER_CH : step;
    unique case (pt)
      5'h00: base = 16'h0194;
      5'h01: base = 16'h0195;
      5'h02: base = 16'h0196;
      5'h03: base = 16'h0197;
      5'h04: base = 16'h0199;
      5'h05: base = 16'h019a;
      5'h06: base = 16'h019b;
      5'h07: base = 16'h019c;
      default: base = 16'h019d;
    endcase
    if (fault != 2'h0) begin
      base = CCS_ERR_TRIG_BASE + {14'h0, fault};
    end
    if (step >= CCS_STEPS_PER_CH) begin
      base = base + CCS_CH2_OFS;
    end
    return base;
  endfunction

  function automatic logic ccs_date_ok(input ccs_date_t d);
    return d.year >= CCS_YEAR_MIN && d.year <= CCS_YEAR_MAX && d.month != 4'h0
      && d.month <= CCS_MONTH_MAX && d.day != 5'h0 && d.day <= CCS_DAY_MAX;
  endfunction
endpackage

// *** logic/ccs_err_queue.sv ***
// error queue of the calibration sequencer
`timescale 1ns/1ps
module ccs_err_queue
  import ccs_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // push and pop
  input wire logic push,
  input wire logic [15:0] push_code,
  input wire logic pop,
  // state
  output logic [15:0] head,
  output logic empty,
  output logic [3:0] count
);
  // ==========================================
  // storage
  logic [15:0] mem_q [CCS_ERR_DEPTH];
  logic [2:0] wp_q, wp_d, rp_q, rp_d;
  logic [3:0] cnt_q, cnt_d;
  logic do_push, do_pop;

  // a full queue drops the newest entry, older faults matter more
  always_comb begin
    do_pop = pop && cnt_q != 4'h0;
    do_push = push && (cnt_q != 4'(CCS_ERR_DEPTH) || do_pop);
    wp_d = do_push ? wp_q + 3'h1 : wp_q;
    rp_d = do_pop ? rp_q + 3'h1 : rp_q;
    cnt_d = cnt_q + {3'h0, do_push} - {3'h0, do_pop};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_q <= 3'h0;
      rp_q <= 3'h0;
      cnt_q <= 4'h0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge hclk) begin
    if (do_push) begin
      mem_q[wp_q] <= push_code;
    end
  end

  assign head = (cnt_q == 4'h0) ? 16'h0 : mem_q[rp_q];
  assign empty = cnt_q == 4'h0;
  assign count = cnt_q;
endmodule

// *** bench/ccs_step_model.sv ***
// behavioural analog step engine facing the sequencer
`timescale 1ns/1ps
module ccs_step_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // from the sequencer
  input wire logic step_go,
  input wire logic [4:0] step_num,
  input wire logic [31:0] step_arg,
  // bench controls
  input wire logic fail_now,
  input wire logic [1:0] fault_now,
  input wire logic [3:0] lag,
  // answer
  output logic step_done,
  output logic step_fail,
  output logic [1:0] step_fault,
  output logic [31:0] step_value
);
  // ==========
  // step answer
  always @(posedge hclk) begin
    if (!hresetn) begin
      step_done <= 1'b0;
      step_fail <= 1'b0;
      step_fault <= 2'h0;
      step_value <= 32'h0;
    end else if (step_go) begin
      repeat (lag) @(posedge hclk);
      step_done <= 1'b1;
      step_fail <= fail_now;
      step_fault <= fail_now ? fault_now : 2'h0;
      step_value <= step_arg ^ {27'h0, step_num};
      @(posedge hclk);
      step_done <= 1'b0;
      // stale lines scrambled so nothing leans on old values
      step_fail <= ~step_fail;
      step_fault <= ~step_fault;
      step_value <= ~step_value;
    end
  end
endmodule

// *** bench/calibration_command_sequencer_bench.sv ***
// self-checking bench of the calibration command sequencer
`timescale 1ns/1ps
module calibration_command_sequencer_bench;
  import ccs_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, step_go, step_done, step_fail, nv_we, srq, irq;
  logic [31:0] hrdata, step_arg, step_value, nv_wdata, r, arg_e;
  logic [4:0] step_num, nv_addr;
  logic [1:0] step_fault;
  logic fail_now = 1'b0;
  logic [1:0] fault_now = 2'h0;
  logic [3:0] lag = 4'h0;
  logic in_save = 1'b0;
  logic [31:0] val_e [18];
  int fail_count = 0;
  int cmp_count = 0;
  int seed = 32'h5e03;
  int eq[$];
  int idx_e = 0;
  int nv_n = 0;
  int nd_n = 0;
  logic [31:0] date_e = 32'h0;
  // out of range first, then the two boundary dates
  logic [31:0] dates [7] = '{32'h07cd_0101, 32'h0832_0101, 32'h07d3_0014, 32'h07d3_0d14,
    32'h07d3_0b00, 32'h0831_0c1f, 32'h07ce_0101};

  always #5 hclk = ~hclk;

  ccs_sequencer ccs_sequencer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .step_go(step_go), .step_num(step_num), .step_arg(step_arg), .step_done(step_done),
    .step_fail(step_fail), .step_fault(step_fault), .step_value(step_value),
    .nv_we(nv_we), .nv_addr(nv_addr), .nv_wdata(nv_wdata), .srq(srq), .irq(irq));

  ccs_step_model ccs_step_model_inst (.hclk(hclk), .hresetn(hresetn), .step_go(step_go),
    .step_num(step_num), .step_arg(step_arg), .fail_now(fail_now), .fault_now(fault_now),
    .lag(lag), .step_done(step_done), .step_fail(step_fail), .step_fault(step_fault),
    .step_value(step_value));

  // ==========
  // checking and closing
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #900000;
    fail_count++;
    stop_test();
  end

  // ==========
  // bus master
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      rd = hrdata;
    end while (hreadyout !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask

  task automatic rdr(input logic [7:0] a);
    xfer(1'b0, a, 32'h0, r);
  endtask

  // command, then wait for busy to fall
  task automatic cmd(input logic [2:0] op, input int n);
    wr(CCS_A_CMD, {19'h0, n[4:0], 5'h0, op});
    repeat (3) @(posedge hclk);
    for (int i = 0; i < 40; i++) begin
      rdr(CCS_A_STAT);
      if (r[11] === 1'b0) break;
    end
    chk("busy", {31'h0, r[11]}, 32'h0);
  endtask

  // ==========
  // reference model
  function automatic int ecode(input int k, input int f);
    int pt;
    int c;
    pt = k % 9;
    c = (f != 0) ? 413 + f : (pt < 4 ? 404 + pt : 405 + pt);
    return (k >= 9) ? c + 20 : c;
  endfunction

  task automatic drain();
    while (eq.size() > 0) begin
      rdr(CCS_A_STAT);
      chk("eav_set", {31'h0, r[16 + CCS_SB_EAV]}, 32'h1);
      rdr(CCS_A_ERRQ);
      chk("err_code", {16'h0, r[15:0]}, eq.pop_front());
    end
    rdr(CCS_A_STAT);
    chk("eav_clr", {31'h0, r[16 + CCS_SB_EAV]}, 32'h0);
  endtask

  task automatic run(input int last, input int fk);
    for (int k = 0; k <= last; k++) begin
      arg_e = $random(seed);
      wr(CCS_A_ARG, arg_e);
      val_e[k] = arg_e ^ 32'(k);
      fail_now <= (k == fk);
      fault_now <= 2'($random(seed));
      lag <= 4'($random(seed));
      idx_e = k;
      cmd(CCS_OP_STEP, k);
      if (k == fk) begin
        eq.push_back(ecode(k, fault_now));
      end
    end
  endtask

  always @(negedge hclk) begin
    if (step_go === 1'b1) begin
      chk("step_num", {27'h0, step_num}, idx_e);
      chk("step_arg", step_arg, arg_e);
    end
    if (nv_we === 1'b1 && nv_addr < 5'h12) begin
      chk("nv_in_save", {31'h0, in_save}, 32'h1);
      chk("nv_addr", {27'h0, nv_addr}, nv_n);
      chk("nv_data", nv_wdata, val_e[nv_n % 18]);
      nv_n++;
    end
    if (nv_we === 1'b1 && nv_addr == 5'h12) begin
      chk("nv_date", nv_wdata, date_e);
      nd_n++;
    end
  end

  // ==========
  // scenarios
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdr(CCS_A_STAT);
    chk("stat_rst", r, 32'h0);
    chk("srq_rst", {31'h0, srq}, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    $display("test reset done");
    for (int op = 3; op <= 6; op++) begin
      cmd(op[2:0], 0);
      eq.push_back(32'hca);
    end
    chk("srq_masked", {31'h0, srq}, 32'h0);
    drain();
    $display("test locked done");
    wr(CCS_A_ARG, CCS_PASSCODE);
    cmd(CCS_OP_UNLOCK, 0);
    wr(CCS_A_SRE, 32'h4);
    for (int op = 4; op <= 6; op++) begin
      cmd(op[2:0], 0);
      eq.push_back(32'hc8);
    end
    chk("srq_on", {31'h0, srq}, 32'h1);
    drain();
    chk("srq_off", {31'h0, srq}, 32'h0);
    $display("test begin order done");
    cmd(CCS_OP_INIT, 0);
    foreach (dates[i]) begin
      date_e = dates[i];
      wr(CCS_A_DATE, dates[i]);
      cmd(CCS_OP_DATE, 0);
      if (i < 5) begin
        eq.push_back(32'hc9);
      end else begin
        rdr(CCS_A_DATE_Q);
        chk("date_q", r, dates[i]);
      end
    end
    drain();
    chk("nv_dates", nd_n, 32'h2);
    $display("test date done");
    wr(CCS_A_IRQ_EN, 32'h4);
    cmd(CCS_OP_STEP, 1);
    eq.push_back(32'hc8);
    rdr(CCS_A_STAT);
    chk("seq_bad", {23'h0, r[8:0]}, 32'h1a0);
    drain();
    cmd(CCS_OP_SAVE, 0);
    rdr(CCS_A_IRQ_ST);
    chk("save_ref", {31'h0, r[2]}, 32'h1);
    chk("irq_on", {31'h0, irq}, 32'h1);
    wr(CCS_A_IRQ_EN, 32'h0);
    rdr(CCS_A_IRQ_ST);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    wr(CCS_A_IRQ_CLR, 32'h7);
    rdr(CCS_A_IRQ_ST);
    chk("irq_clr", r, 32'h0);
    $display("test order done");
    for (int k = 0; k < 18; k++) begin
      cmd(CCS_OP_INIT, 0);
      run(k, k);
      drain();
    end
    cmd(CCS_OP_SAVE, 0);
    rdr(CCS_A_IRQ_ST);
    chk("save_invalid", r[2:1], 32'h2);
    wr(CCS_A_IRQ_CLR, 32'h7);
    $display("test failures done");
    cmd(CCS_OP_INIT, 0);
    run(17, -1);
    chk("nv_early", nv_n, 32'h0);
    in_save = 1'b1;
    cmd(CCS_OP_SAVE, 0);
    in_save = 1'b0;
    chk("nv_count", nv_n, 32'h12);
    rdr(CCS_A_IRQ_ST);
    chk("save_ok", r[2:1], 32'h1);
    cmd(CCS_OP_LOCK, 0);
    rdr(CCS_A_STAT);
    chk("stat_lock", {23'h0, r[8:0]}, 32'h0);
    cmd(CCS_OP_STEP, 0);
    eq.push_back(32'hca);
    drain();
    $display("test save done");
    stop_test();
  end
endmodule
